/* inc/tcs_consts.vh */
// Register map, field positions, reset values and timing counts of the converter config block
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TCS_OFF_CFG0      8'h00
`define TCS_OFF_CFG_LAST  8'h18
`define TCS_OFF_CMD       8'h20
`define TCS_OFF_STATUS    8'h24
`define TCS_OFF_RES0      8'h28
`define TCS_OFF_RES2      8'h30
`define TCS_OFF_NVM_INJ   8'h34

// ----------------------------------------------------------------
// Command codes written to the command register
// ----------------------------------------------------------------
`define TCS_CMD_POR       8'h50
`define TCS_CMD_INIT      8'h70
`define TCS_CMD_NVM_WR    8'h51
`define TCS_CMD_NVM_LD    8'h52
`define TCS_CMD_NVM_CMP   8'h53

// ----------------------------------------------------------------
// Config word 0 fields and config word reset values
// ----------------------------------------------------------------
`define TCS_CFG_MODE2     0
`define TCS_CFG_FIRE_EN   1
`define TCS_CFG_HITS_LO   2
`define TCS_CFG_HITS_HI   3
`define TCS_CFG0_RST      32'h0000_0004
`define TCS_CFG_RST       32'h0000_0000

// ----------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------
`define TCS_ST_MATCH      0
`define TCS_ST_UNCORR     1
`define TCS_ST_CORR       2
`define TCS_ST_SHORT      3
`define TCS_ST_OPEN       4
`define TCS_ST_PRE_TO     5
`define TCS_ST_FINE_TO    6
`define TCS_ST_NVM_BUSY   7
`define TCS_ST_MEAS_BUSY  8
`define TCS_ST_MEAS_DONE  9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TCS_CLK_MHZ       250
`define TCS_FIRE_KHZ      1000
`define TCS_FIRE_PULSES   30
`define TCS_FIRE_HALF_CYC (`TCS_CLK_MHZ * 1000 / `TCS_FIRE_KHZ / 2)
`define TCS_M1_MIN_PS     3500
`define TCS_M1_MIN_CYC    ((`TCS_M1_MIN_PS * `TCS_CLK_MHZ + 999999) / 1000000)
`define TCS_M1_MAX_NS     2500
`define TCS_M1_MAX_CYC    (`TCS_M1_MAX_NS * `TCS_CLK_MHZ / 1000)
`define TCS_M2_MIN_NS     500
`define TCS_M2_MIN_CYC    ((`TCS_M2_MIN_NS * `TCS_CLK_MHZ + 999) / 1000)
`define TCS_M2_MAX_NS     4000000
`define TCS_M2_MAX_CYC    (`TCS_M2_MAX_NS / 1000 * `TCS_CLK_MHZ)
`define TCS_PRE_BITS      14
`define TCS_MASK_UNIT_CYC 2

`endif

/* core/tcs_top.v */
// Converter config/status register bank with nonvolatile copy and measurement engine
`timescale 1ns/100ps
`include "tcs_consts.vh"
module tcs_top #(
    parameter NWORDS      = 7,
    parameter M2_MAX_CYC  = `TCS_M2_MAX_CYC
) (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        start_in,
    input  wire        stop_in,
    input  wire        temp_short_in,
    input  wire        temp_open_in,
    output wire        fire_out
);
    localparam PRE_TICK = M2_MAX_CYC >> `TCS_PRE_BITS;
    localparam [3:0] M_IDLE = 4'h1, M_ARMED = 4'h2, M_RUN = 4'h4, M_DONE = 4'h8;
    localparam [3:0] N_IDLE = 4'h1, N_WR = 4'h2, N_LD = 4'h4, N_CMP = 4'h8;
    localparam [31:0] FIRE_N = `TCS_FIRE_PULSES;
    // ----------------------------------------------------------------
    // Nonvolatile word check: two parity-protected copies per word
    // ----------------------------------------------------------------
    // Returns {uncorrectable, corrected, data}
    function [33:0] nvm_fix;
        input [32:0] a;
        input [32:0] b;
        reg          ga, gb;
        begin
            ga = ~^a;
            gb = ~^b;
            if (ga && gb && a == b)
                nvm_fix = {2'b00, a[31:0]};
            else if (ga && !gb)
                nvm_fix = {2'b01, a[31:0]};
            else if (!ga && gb)
                nvm_fix = {2'b01, b[31:0]};
            else
                nvm_fix = {2'b10, a[31:0]};
        end
    endfunction
    // ----------------------------------------------------------------
    // Pin synchronisers: three stages, change taken when 2 and 3 agree
    // ----------------------------------------------------------------
    wire [3:0] pin_raw = {temp_open_in, temp_short_in, stop_in, start_in};
    reg  [3:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_stb_r, pin_prev_r;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            always @(posedge clk_sys) begin
                if (!rstn) begin
                    {pin_s1_r[gi], pin_s2_r[gi], pin_s3_r[gi], pin_stb_r[gi], pin_prev_r[gi]} <= 5'b00000;
                end else begin
                    pin_s1_r[gi]   <= pin_raw[gi];
                    pin_s2_r[gi]   <= pin_s1_r[gi];
                    pin_s3_r[gi]   <= pin_s2_r[gi];
                    if (pin_s2_r[gi] == pin_s3_r[gi])
                        pin_stb_r[gi] <= pin_s3_r[gi];
                    pin_prev_r[gi] <= pin_stb_r[gi];
                end
            end
        end
    endgenerate
    wire start_rise = pin_stb_r[0] & ~pin_prev_r[0];
    wire stop_rise  = pin_stb_r[1] & ~pin_prev_r[1];
    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    reg        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    reg        aw_got_r, w_got_r;
    reg [7:0]  awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0]  wstrb_r;
    reg [1:0]  bresp_r, rresp_r;
    reg [31:0] rdata_r;
    reg [31:0] rd_nxt;
    reg        rd_ok;
    wire       wr_go  = aw_got_r & w_got_r & ~bvalid_r;
    wire       wr_cfg = wr_go && awaddr_r <= `TCS_OFF_CFG_LAST && awaddr_r[1:0] == 2'b00;
    wire [2:0] wr_idx = awaddr_r[4:2];
    wire       wr_cmd = wr_go && awaddr_r == `TCS_OFF_CMD && wstrb_r[0];
    wire       wr_inj = wr_go && awaddr_r == `TCS_OFF_NVM_INJ && wstrb_r[1];
    wire       wr_map = awaddr_r[1:0] == 2'b00 && (awaddr_r <= `TCS_OFF_CFG_LAST ||
                        (awaddr_r >= `TCS_OFF_CMD && awaddr_r <= `TCS_OFF_NVM_INJ));
    wire       cmd_por  = wr_cmd && wdata_r[7:0] == `TCS_CMD_POR;
    wire       cmd_init = wr_cmd && wdata_r[7:0] == `TCS_CMD_INIT;
    always @(posedge clk_sys) begin
        if (!rstn) begin
            {awready_r, wready_r, bvalid_r, aw_got_r, w_got_r} <= 5'b00000;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bresp_r   <= 2'b00;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awready_r <= 1'b0;
                aw_got_r  <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (!aw_got_r && !bvalid_r) begin
                awready_r <= 1'b1;
            end
            if (s_axi_wvalid && wready_r) begin
                wready_r <= 1'b0;
                w_got_r  <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (!w_got_r && !bvalid_r) begin
                wready_r <= 1'b1;
            end
            if (wr_go) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wr_map ? 2'b00 : 2'b10;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    // ----------------------------------------------------------------
    // Configuration words, nonvolatile store and its sequencer
    // ----------------------------------------------------------------
    reg [31:0] cfg_r [0:NWORDS-1];
    reg [32:0] nvm_a [0:NWORDS-1];
    reg [32:0] nvm_b [0:NWORDS-1];
    reg [3:0]  nvm_st_r;
    reg [2:0]  nvm_idx_r;
    reg        nvm_diff_r;
    reg        match_r, uncorr_r, corr_r;
    wire [33:0] nvm_rd   = nvm_fix(nvm_a[nvm_idx_r], nvm_b[nvm_idx_r]);
    wire        nvm_last = nvm_idx_r == NWORDS - 1;
    wire        nvm_idle = nvm_st_r == N_IDLE;
    wire        nvm_rd_start = nvm_idle && wr_cmd &&
                    (wdata_r[7:0] == `TCS_CMD_NVM_LD || wdata_r[7:0] == `TCS_CMD_NVM_CMP);
    integer k, k2;
    always @(posedge clk_sys) begin
        if (!rstn || cmd_por) begin
            for (k = 0; k < NWORDS; k = k + 1)
                cfg_r[k] <= (k == 0) ? `TCS_CFG0_RST : `TCS_CFG_RST;
        end else if (nvm_st_r == N_LD && !nvm_rd[33]) begin
            cfg_r[nvm_idx_r] <= nvm_rd[31:0];
        end else if (wr_cfg && nvm_idle) begin
            for (k = 0; k < 4; k = k + 1)
                if (wstrb_r[k])
                    cfg_r[wr_idx][k*8 +: 8] <= wdata_r[k*8 +: 8];
        end
    end
    // Store contents are kept across every reset, as a nonvolatile part would
    always @(posedge clk_sys) begin
        if (nvm_st_r == N_WR) begin
            nvm_a[nvm_idx_r] <= {^cfg_r[nvm_idx_r], cfg_r[nvm_idx_r]};
            nvm_b[nvm_idx_r] <= {^cfg_r[nvm_idx_r], cfg_r[nvm_idx_r]};
        end else if (wr_inj && nvm_idle) begin
            nvm_a[wdata_r[2:0]][0] <= nvm_a[wdata_r[2:0]][0] ^ wdata_r[8];
            nvm_b[wdata_r[2:0]][0] <= nvm_b[wdata_r[2:0]][0] ^ wdata_r[9];
        end
    end
    always @(posedge clk_sys) begin
        if (!rstn || cmd_por) begin
            nvm_st_r   <= N_IDLE;
            nvm_idx_r  <= 3'd0;
            {nvm_diff_r, match_r, uncorr_r, corr_r} <= 4'h0;
        end else begin
            // A fresh read sequence restarts error reporting; set still wins below
            uncorr_r <= (uncorr_r & ~nvm_rd_start) |
                        ((nvm_st_r == N_LD || nvm_st_r == N_CMP) & nvm_rd[33]);
            corr_r   <= (corr_r & ~nvm_rd_start) |
                        ((nvm_st_r == N_LD || nvm_st_r == N_CMP) & nvm_rd[32]);
            case (nvm_st_r)
                N_IDLE: begin
                    nvm_idx_r  <= 3'd0;
                    nvm_diff_r <= 1'b0;
                    if (wr_cmd) begin
                        case (wdata_r[7:0])
                            `TCS_CMD_NVM_WR:  nvm_st_r <= N_WR;
                            `TCS_CMD_NVM_LD:  nvm_st_r <= N_LD;
                            `TCS_CMD_NVM_CMP: nvm_st_r <= N_CMP;
                            default:          nvm_st_r <= N_IDLE;
                        endcase
                    end
                end
                N_WR, N_LD: begin
                    nvm_idx_r <= nvm_idx_r + 3'd1;
                    if (nvm_last)
                        nvm_st_r <= N_IDLE;
                end
                N_CMP: begin
                    nvm_idx_r <= nvm_idx_r + 3'd1;
                    if (nvm_rd[33] || nvm_rd[31:0] != cfg_r[nvm_idx_r])
                        nvm_diff_r <= 1'b1;
                    if (nvm_last) begin
                        nvm_st_r <= N_IDLE;
                        match_r  <= ~nvm_diff_r & ~nvm_rd[33] &
                                    (nvm_rd[31:0] == cfg_r[nvm_idx_r]);
                    end
                end
                default: nvm_st_r <= N_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // Measurement engine and fire burst
    // ----------------------------------------------------------------
    reg [3:0]  m_st_r;
    reg [31:0] cnt_r, tick_r;
    reg [`TCS_PRE_BITS-1:0] pre_r;
    reg [1:0]  hit_r;
    reg [31:0] res_r [0:2];
    reg        pre_to_r, fine_to_r, short_r, open_r;
    reg [4:0]  fire_left_r;
    reg [7:0]  fire_half_r;
    reg        fire_r;
    wire       mode2    = cfg_r[0][`TCS_CFG_MODE2];
    wire [1:0] hits_exp = cfg_r[0][`TCS_CFG_HITS_HI:`TCS_CFG_HITS_LO];
    wire [31:0] mask_cyc = cfg_r[1][15:0] * `TCS_MASK_UNIT_CYC;
    wire [31:0] min_cyc  = mode2 ? `TCS_M2_MIN_CYC : `TCS_M1_MIN_CYC;
    wire       stop_ok  = m_st_r == M_RUN && stop_rise &&
                          cnt_r >= mask_cyc && cnt_r >= min_cyc;
    wire       fine_end = !mode2 && cnt_r == `TCS_M1_MAX_CYC - 1;
    wire       tick_end = tick_r == PRE_TICK - 1;
    wire       pre_end  = mode2 && tick_end && (&pre_r);
    wire       m_clr    = !rstn || cmd_por;
    always @(posedge clk_sys) begin
        if (m_clr || cmd_init) begin
            m_st_r    <= m_clr ? M_IDLE : M_ARMED;
            cnt_r     <= 32'h0000_0000;
            tick_r    <= 32'h0000_0000;
            pre_r     <= {`TCS_PRE_BITS{1'b0}};
            hit_r     <= 2'd0;
            {pre_to_r, fine_to_r} <= 2'b00;
            // Results survive a rearm so the host can still read the last run
            if (m_clr)
                for (k2 = 0; k2 < 3; k2 = k2 + 1)
                    res_r[k2] <= 32'h0000_0000;
        end else begin
            case (m_st_r)
                M_IDLE, M_DONE: m_st_r <= m_st_r;
                M_ARMED: begin
                    if (start_rise)
                        m_st_r <= M_RUN;
                end
                M_RUN: begin
                    cnt_r  <= cnt_r + 32'd1;
                    tick_r <= tick_end ? 32'h0000_0000 : tick_r + 32'd1;
                    if (tick_end)
                        pre_r <= pre_r + 1'b1;
                    if (stop_ok) begin
                        res_r[hit_r] <= cnt_r;
                        hit_r <= hit_r + 2'd1;
                        if (hit_r + 2'd1 >= hits_exp || hit_r == 2'd2)
                            m_st_r <= M_DONE;
                    end else if (pre_end) begin
                        pre_to_r <= 1'b1;
                        m_st_r   <= M_DONE;
                    end else if (fine_end) begin
                        fine_to_r <= 1'b1;
                        m_st_r    <= M_DONE;
                    end
                end
                default: m_st_r <= M_IDLE;
            endcase
        end
    end
    // Sensor faults stick until a full reset; a fault present then sets again
    always @(posedge clk_sys) begin
        if (!rstn) begin
            {short_r, open_r} <= 2'b00;
        end else begin
            short_r <= (short_r & ~cmd_por) | pin_stb_r[2];
            open_r  <= (open_r & ~cmd_por) | pin_stb_r[3];
        end
    end
    always @(posedge clk_sys) begin
        if (m_clr || (cmd_init && cfg_r[0][`TCS_CFG_FIRE_EN])) begin
            fire_left_r <= m_clr ? 5'd0 : FIRE_N[4:0];
            fire_half_r <= 8'd0;
            fire_r      <= 1'b0;
        end else if (fire_left_r != 5'd0) begin
            if (fire_half_r == `TCS_FIRE_HALF_CYC - 1) begin
                fire_half_r <= 8'd0;
                fire_r      <= ~fire_r;
                if (fire_r)
                    fire_left_r <= fire_left_r - 5'd1;
            end else begin
                fire_half_r <= fire_half_r + 8'd1;
            end
        end
    end
    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [31:0] status = {22'h0, m_st_r == M_DONE, m_st_r == M_RUN || m_st_r == M_ARMED, ~nvm_idle,
                          fine_to_r, pre_to_r, open_r, short_r, corr_r, uncorr_r, match_r};
    always @* begin
        rd_nxt = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (s_axi_araddr[1:0] != 2'b00)
            rd_ok = 1'b0;
        else if (s_axi_araddr <= `TCS_OFF_CFG_LAST)
            rd_nxt = cfg_r[s_axi_araddr[4:2]];
        else if (s_axi_araddr == `TCS_OFF_STATUS)
            rd_nxt = status;
        else if (s_axi_araddr >= `TCS_OFF_RES0 && s_axi_araddr <= `TCS_OFF_RES2)
            rd_nxt = res_r[s_axi_araddr[3:2] - 2'd2];
        else if (s_axi_araddr != `TCS_OFF_CMD && s_axi_araddr != `TCS_OFF_NVM_INJ)
            rd_ok = 1'b0;
    end
    always @(posedge clk_sys) begin
        if (!rstn) begin
            {arready_r, rvalid_r} <= 2'b00;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= 2'b00;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_nxt;
            rresp_r   <= rd_ok ? 2'b00 : 2'b10;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end else if (!rvalid_r) begin
            arready_r <= 1'b1;
        end
    end
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign fire_out      = fire_r;
endmodule // tcs_top

/* verification/tcs_checker.sv */
// Port assertions for the converter register bank
`timescale 1ns/100ps
module tcs_checker (
    input logic        clk_sys,
    input logic        rstn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        fire_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Fire high phase must be exactly half of the 1 MHz period
    logic [7:0] hi_r;
    always_ff @(posedge clk_sys) begin
        if (!rstn || !fire_out) hi_r <= 8'h00;
        else hi_r <= hi_r + 8'h01;
    end
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h34
        || s_axi_araddr[1:0] != 2'h0) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_fire_half: assert property ($fell(fire_out) |-> hi_r == 8'd125)
        else $error("fire high phase wrong");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_fire: cover property ($rose(fire_out));
endmodule // tcs_checker

bind tcs_top tcs_checker i_chk (.*);

/* verification/tcs_pin_model.sv */
// Pin-side model: start/stop pulses, sensor faults, fire pulse counter
`timescale 1ns/100ps
module tcs_pin_model (
    input  logic clk_sys,
    input  logic fire_out,
    output logic start_in,
    output logic stop_in,
    output logic temp_short_in,
    output logic temp_open_in
);
    int fire_cnt = 0;
    initial {start_in, stop_in, temp_short_in, temp_open_in} = 4'h0;
    always @(posedge fire_out) fire_cnt++;
    task automatic sens(input logic s, input logic o);
        @(posedge clk_sys);
        temp_short_in <= s;
        temp_open_in <= o;
    endtask
    // Start pulse, then n stop pulses every gap cycles; pulses 4 cycles wide
    task automatic shot(input int n, input int gap);
        for (int t = 0; t <= n * gap + 4; t++) begin
            @(posedge clk_sys);
            start_in <= (t < 4);
            stop_in <= (n > 0 && t >= gap && t < n * gap + 4 && t % gap < 4);
        end
    endtask
endmodule // tcs_pin_model

/* verification/testbench.sv */
// Self-checking bench for the converter register bank
`timescale 1ns/100ps
`include "tcs_consts.vh"
module testbench;
    logic        clk_sys = 0, rstn = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, rv;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [1:0]  rsp;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire         start_in, stop_in, temp_short_in, temp_open_in, fire_out;
    int          err_total = 0, num_checks = 0, cyc = 0, c;
    always #2 clk_sys = ~clk_sys;
    tcs_top #(.M2_MAX_CYC(65536)) i_dut (.*);
    tcs_pin_model i_pins (.*);
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            err_total++;
            test_done();
        end
    end
    task test_done;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ----------------------------------------
    // Register bus tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ga, gw;
        ga = 0;
        gw = 0;
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ga && gw)) begin
            @(posedge clk_sys);
            if (!ga && s_axi_awready) begin ga = 1; s_axi_awvalid <= 0; end
            if (!gw && s_axi_wready) begin gw = 1; s_axi_wvalid <= 0; end
        end
        do @(posedge clk_sys); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        {rv, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 0;
    endtask
    task automatic cmd(input logic [7:0] k);
        wr(`TCS_OFF_CMD, {24'h0, k});
        for (int i = 0; i < 20; i++) begin
            rd(`TCS_OFF_STATUS);
            if (rv[`TCS_ST_NVM_BUSY] === 1'b0) break;
        end
    endtask
    task automatic near(input logic [7:0] a, input int exp);
        rd(a);
        check("hit_time", 32'(rv >= exp - 2 && rv <= exp + 2), 32'h1);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1;
        rd(`TCS_OFF_CFG0); check("cfg0_reset", rv, `TCS_CFG0_RST);
        rd(8'h3c); check("rd_unmapped", 32'(rsp), 32'h2);
        wr(8'h1c, 32'h0); check("wr_unmapped", 32'(rsp), 32'h2);
        for (int i = 0; i < 7; i++) wr(8'(i * 4), 32'h1230_0000 + i * 32'h11);
        cmd(`TCS_CMD_NVM_WR);
        cmd(`TCS_CMD_NVM_CMP); check("match_eq", 32'(rv[`TCS_ST_MATCH]), 32'h1);
        wr(8'h08, 32'h0); cmd(`TCS_CMD_NVM_CMP); check("match_ne", 32'(rv[`TCS_ST_MATCH]), 32'h0);
        cmd(`TCS_CMD_NVM_LD); rd(8'h08); check("cfg2_loaded", rv, 32'h1230_0022);
        wr(`TCS_OFF_NVM_INJ, 32'h102); cmd(`TCS_CMD_NVM_CMP);
        check("corrected", 32'(rv[`TCS_ST_CORR]), 32'h1);
        wr(`TCS_OFF_NVM_INJ, 32'h303); cmd(`TCS_CMD_NVM_CMP);
        check("uncorrectable", 32'(rv[`TCS_ST_UNCORR]), 32'h1);
        check("match_bad", 32'(rv[`TCS_ST_MATCH]), 32'h0);
        i_pins.sens(1, 0); repeat (10) @(posedge clk_sys); rd(`TCS_OFF_STATUS);
        check("short", 32'(rv[`TCS_ST_SHORT]), 32'h1);
        i_pins.sens(0, 1); repeat (10) @(posedge clk_sys); rd(`TCS_OFF_STATUS);
        check("open", 32'(rv[`TCS_ST_OPEN]), 32'h1);
        // Sensor pins must settle through the synchroniser before the reset, or a flag sets again
        i_pins.sens(0, 0); repeat (10) @(posedge clk_sys);
        cmd(`TCS_CMD_POR); check("flags_cleared", rv & 32'h7f, 32'h0);
        rd(8'h08); check("cfg2_cleared", rv, `TCS_CFG_RST);
        wr(`TCS_OFF_CFG0, 32'h4); cmd(`TCS_CMD_INIT); i_pins.shot(1, 100);
        repeat (20) @(posedge clk_sys); near(`TCS_OFF_RES0, 100);
        rd(`TCS_OFF_STATUS); check("meas_done", 32'(rv[`TCS_ST_MEAS_DONE]), 32'h1);
        cmd(`TCS_CMD_INIT); i_pins.shot(0, 0); repeat (700) @(posedge clk_sys);
        rd(`TCS_OFF_STATUS); check("fine_timeout", 32'(rv[`TCS_ST_FINE_TO]), 32'h1);
        wr(`TCS_OFF_CFG0, 32'hd); wr(8'h04, 32'd100); cmd(`TCS_CMD_INIT); i_pins.shot(4, 140);
        repeat (20) @(posedge clk_sys);
        for (int k = 0; k < 3; k++) near(8'(`TCS_OFF_RES0 + 4 * k), 280 + 140 * k);
        rd(`TCS_OFF_CFG0); check("cfg_kept", rv, 32'hd);
        cmd(`TCS_CMD_INIT); i_pins.shot(0, 0); repeat (66000) @(posedge clk_sys);
        rd(`TCS_OFF_STATUS); check("pre_timeout", 32'(rv[`TCS_ST_PRE_TO]), 32'h1);
        wr(`TCS_OFF_CFG0, 32'h6); c = i_pins.fire_cnt; cmd(`TCS_CMD_INIT);
        check("armed", 32'(rv[`TCS_ST_MEAS_BUSY]), 32'h1);
        repeat (7800) @(posedge clk_sys);
        check("fire_pulses", 32'(i_pins.fire_cnt - c), 32'd30);
        test_done();
    end
endmodule // testbench
